// ### hw/fmsp_defines.svh
/*
  Constants of the four-mode serial port: register indices, field
  positions, reset values and divider counts.
  Assumes it is included by bare name wherever these are needed.
*/
`ifndef FMSP_DEFINES_SVH
`define FMSP_DEFINES_SVH

// ==========================================================================
// Register map (index, byte address is four times the index)
`define FMSP_IDX_CONTROL     8'h98
`define FMSP_IDX_BUFFER      8'h99
`define FMSP_IDX_BAUD        8'h9A

// ==========================================================================
// Control register field positions
`define FMSP_CTL_MODE_HI     7
`define FMSP_CTL_MODE_LO     6
`define FMSP_CTL_MPFILTER    5
`define FMSP_CTL_RXENABLE    4
`define FMSP_CTL_TXNINTH     3
`define FMSP_CTL_RXNINTH     2
`define FMSP_CTL_TXDONE      1
`define FMSP_CTL_RXDONE      0

// Baud register field positions
`define FMSP_BAUD_DOUBLE     0
`define FMSP_BAUD_TXT2       1
`define FMSP_BAUD_RXT2       2

// Reset values
`define FMSP_RST_CONTROL     8'h00
`define FMSP_RST_BUFFER      8'h00
`define FMSP_RST_BAUD        8'h00

// ==========================================================================
// Timing: core clock period, shift-mode divider, oversampling
`define FMSP_CORE_CLK_NS     10
`define FMSP_SHIFT_DIV       12
`define FMSP_SHIFT_HALF      (`FMSP_SHIFT_DIV / 2)
`define FMSP_OVERSAMPLE      16
`define FMSP_FIX_DIV_SLOW    64
`define FMSP_FIX_DIV_FAST    32

`endif

// ### hw/fmsp_pkg.sv
/*
  Types of the four-mode serial port: operating modes, state
  machine encodings.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fmsp_pkg;

  // ========================================================================
  // Operating modes, selected by the two mode bits
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_8BIT  = 2'b01,
    MODE_9FIX  = 2'b10,
    MODE_9VAR  = 2'b11
  } fmsp_mode_t;

  // Transmit engine states
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_ASYNC = 3'b010,
    TX_SYNC  = 3'b100
  } fmsp_tx_t;

  // Receive engine states
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_SYNC  = 4'b1000
  } fmsp_rx_t;

endpackage : fmsp_pkg

// ### hw/fmsp_serial_port.sv
/*
  Four-mode serial port with an AHB-Lite register slave.
  Assumes one clock (mclk), timer overflow pulses from logic on the
  same clock, and an asynchronous serial input pin.
*/
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/10ps
`include "fmsp_defines.svh"

module fmsp_serial_port (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Serial pins
  input  wire logic        serialInPin,
  output logic             serialInOut,
  output logic             serialInOe,
  output logic             serialOutPin,
  // Timer overflows and power management
  input  wire logic        timer1Ovf,
  input  wire logic        timer2Ovf,
  input  wire logic        powerManagedSlowMode,
  output logic             wakeRequest
);

  // ========================================================================
  // State record
  typedef struct packed {
    logic                hreadyout;
    logic [31:0]         hrdata;
    logic                rdPend;
    logic                wrPend;
    logic                addrOk;
    logic [7:0]          addrIdx;
    logic [1:0]          mode;
    logic                mpFilter;
    logic                rxEnable;
    logic                txNinth;
    logic                rxNinth;
    logic                txDone;
    logic                rxDone;
    logic                baudDouble;
    logic                txT2Sel;
    logic                rxT2Sel;
    logic [7:0]          rxBuf;
    fmsp_pkg::fmsp_tx_t  txState;
    logic [10:0]         txShift;
    logic [3:0]          txBitCnt;
    logic [3:0]          txTick;
    fmsp_pkg::fmsp_rx_t  rxState;
    logic [9:0]          rxShift;
    logic [3:0]          rxBitCnt;
    logic [3:0]          rxTick;
    logic [3:0]          shiftCnt;
    logic                t1Half;
    logic [1:0]          fixDiv;
    logic                serialOut;
    logic                lineOe;
    logic                rxS1;
    logic                rxS2;
    logic                rxS3;
    logic                wake;
  } fmsp_state_t;

  localparam fmsp_state_t RST_STATE = '{
    hreadyout : 1'b1,
    hrdata    : 32'h0000_0000,
    rdPend    : 1'b0,
    wrPend    : 1'b0,
    addrOk    : 1'b0,
    addrIdx   : 8'h00,
    mode      : 2'(`FMSP_RST_CONTROL >> `FMSP_CTL_MODE_LO),
    mpFilter  : 1'b0,
    rxEnable  : 1'b0,
    txNinth   : 1'b0,
    rxNinth   : 1'b0,
    txDone    : 1'b0,
    rxDone    : 1'b0,
    baudDouble: 1'b0,
    txT2Sel   : 1'b0,
    rxT2Sel   : 1'b0,
    rxBuf     : `FMSP_RST_BUFFER,
    txState   : fmsp_pkg::TX_IDLE,
    txShift   : 11'h7FF,
    txBitCnt  : 4'h0,
    txTick    : 4'h0,
    rxState   : fmsp_pkg::RX_IDLE,
    rxShift   : 10'h000,
    rxBitCnt  : 4'h0,
    rxTick    : 4'h0,
    shiftCnt  : 4'h0,
    t1Half    : 1'b0,
    fixDiv    : 2'h0,
    serialOut : 1'b1,
    lineOe    : 1'b0,
    rxS1      : 1'b1,
    rxS2      : 1'b1,
    rxS3      : 1'b1,
    wake      : 1'b0
  };

  localparam logic [3:0] SHIFT_FALL = 4'(`FMSP_SHIFT_HALF - 1);
  localparam logic [3:0] SHIFT_LAST = 4'(`FMSP_SHIFT_DIV - 1);
  localparam logic [3:0] OS_LAST    = 4'(`FMSP_OVERSAMPLE - 1);
  localparam logic [3:0] OS_MID     = 4'(`FMSP_OVERSAMPLE / 2 - 1);
  localparam logic [1:0] FIX_SLOW   =
    2'(`FMSP_FIX_DIV_SLOW / `FMSP_OVERSAMPLE - 1);
  localparam logic [1:0] FIX_FAST   =
    2'(`FMSP_FIX_DIV_FAST / `FMSP_OVERSAMPLE - 1);

  fmsp_state_t s_r;
  fmsp_state_t s_nxt;

  // ========================================================================
  // Register read decode
  function automatic logic [7:0] readReg(input fmsp_state_t st);
    logic [7:0] v;
    v = 8'h00;
    if (st.addrOk) begin
      unique case (st.addrIdx)
        `FMSP_IDX_CONTROL: v = {st.mode, st.mpFilter, st.rxEnable,
                                st.txNinth, st.rxNinth, st.txDone,
                                st.rxDone};
        `FMSP_IDX_BUFFER:  v = st.rxBuf;
        `FMSP_IDX_BAUD:    v = {5'h00, st.rxT2Sel, st.txT2Sel,
                                st.baudDouble};
        default:           v = 8'h00;
      endcase
    end
    return v;
  endfunction : readReg

  // ========================================================================
  // Next-state logic
  always_comb begin
    logic       osTick;
    logic       rxLvl;
    logic       accept;
    logic       wrCtl;
    logic       wrBuf;
    logic       wrBaud;
    logic       txSet;
    logic       rxSet;
    logic       nineBit;
    logic [9:0] frame;
    logic       ninth;
    osTick = 1'b0;
    accept = 1'b0;
    txSet  = 1'b0;
    rxSet  = 1'b0;
    frame  = 10'h000;
    ninth  = 1'b0;
    s_nxt  = s_r;

    // Pin synchroniser; the second stage gives the level, the third only the edge
    s_nxt.rxS1 = serialInPin;
    s_nxt.rxS2 = s_r.rxS1;
    s_nxt.rxS3 = s_r.rxS2;
    rxLvl      = s_r.rxS2;
    nineBit    = s_r.mode[1];

    // Any line edge in slow mode with receive enabled asks for wake-up
    s_nxt.wake = powerManagedSlowMode & s_r.rxEnable
               & (s_r.rxS2 ^ s_r.rxS3);

    // Oversample tick: fixed divider or selected timer overflow
    if (timer1Ovf) begin
      s_nxt.t1Half = ~s_r.t1Half;
    end
    if (s_r.mode == fmsp_pkg::MODE_9FIX) begin
      if (s_r.fixDiv >= (s_r.baudDouble ? FIX_FAST : FIX_SLOW)) begin
        s_nxt.fixDiv = 2'h0;
        osTick       = 1'b1;
      end else begin
        s_nxt.fixDiv = s_r.fixDiv + 2'h1;
      end
    end else begin
      s_nxt.fixDiv = 2'h0;
      // Either timer 2 select overrides the timer 1 choice
      if (s_r.txT2Sel | s_r.rxT2Sel) begin
        osTick = timer2Ovf;
      end else begin
        osTick = timer1Ovf & (s_r.baudDouble | s_r.t1Half);
      end
    end

    // Bus: reads take one wait state so a write just before is seen
    s_nxt.hreadyout = 1'b1;
    s_nxt.rdPend    = 1'b0;
    s_nxt.wrPend    = 1'b0;
    if (s_r.rdPend) begin
      s_nxt.hrdata = {24'h00_0000, readReg(s_r)};
    end
    accept = hsel & htrans[1] & hready;
    if (accept) begin
      s_nxt.addrIdx = haddr[9:2];
      s_nxt.addrOk  = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00);
      if (hwrite) begin
        s_nxt.wrPend = 1'b1;
      end else begin
        s_nxt.rdPend    = 1'b1;
        s_nxt.hreadyout = 1'b0;
      end
    end
    wrCtl  = s_r.wrPend & s_r.addrOk & (s_r.addrIdx == `FMSP_IDX_CONTROL);
    wrBuf  = s_r.wrPend & s_r.addrOk & (s_r.addrIdx == `FMSP_IDX_BUFFER);
    wrBaud = s_r.wrPend & s_r.addrOk & (s_r.addrIdx == `FMSP_IDX_BAUD);

    // Transmit engine
    unique case (s_r.txState)
      fmsp_pkg::TX_IDLE: begin
        if (wrBuf) begin
          if (s_r.mode == fmsp_pkg::MODE_SHIFT) begin
            // Line is shared, so no send while a receive runs
            if (!s_r.txDone && s_r.rxState == fmsp_pkg::RX_IDLE) begin
              s_nxt.txState  = fmsp_pkg::TX_SYNC;
              s_nxt.txShift  = {3'b111, hwdata[7:0]};
              s_nxt.txBitCnt = 4'h0;
              s_nxt.shiftCnt = 4'h0;
              s_nxt.serialOut = 1'b1;
              s_nxt.lineOe   = ~hwdata[0];
            end
          end else begin
            // Stop bit above ninth; 8-bit frames stop one bit early
            s_nxt.txState  = fmsp_pkg::TX_ASYNC;
            s_nxt.txShift  = {1'b1, nineBit ? s_r.txNinth : 1'b1,
                              hwdata[7:0], 1'b0};
            s_nxt.txBitCnt = 4'h0;
            s_nxt.txTick   = 4'h0;
            s_nxt.serialOut = 1'b0;
          end
        end
      end
      fmsp_pkg::TX_ASYNC: begin
        if (osTick) begin
          s_nxt.txTick = s_r.txTick + 4'h1;
          if (s_r.txTick == OS_LAST) begin
            s_nxt.txShift  = {1'b1, s_r.txShift[10:1]};
            s_nxt.serialOut = s_r.txShift[1];
            s_nxt.txBitCnt = s_r.txBitCnt + 4'h1;
            if (s_r.txBitCnt == (nineBit ? 4'd10 : 4'd9)) begin
              s_nxt.serialOut = 1'b1;
              s_nxt.txState  = fmsp_pkg::TX_IDLE;
              txSet          = 1'b1;
            end
          end
        end
      end
      fmsp_pkg::TX_SYNC: begin
        s_nxt.shiftCnt = s_r.shiftCnt + 4'h1;
        if (s_r.shiftCnt == SHIFT_FALL) begin
          s_nxt.serialOut = 1'b0;
        end
        if (s_r.shiftCnt == SHIFT_LAST) begin
          s_nxt.shiftCnt  = 4'h0;
          s_nxt.serialOut = 1'b1;
          s_nxt.txShift   = {1'b1, s_r.txShift[10:1]};
          s_nxt.lineOe    = ~s_r.txShift[1];
          s_nxt.txBitCnt  = s_r.txBitCnt + 4'h1;
          if (s_r.txBitCnt == 4'd7) begin
            s_nxt.lineOe  = 1'b0;
            s_nxt.txState = fmsp_pkg::TX_IDLE;
            txSet         = 1'b1;
          end
        end
      end
      default: s_nxt.txState = fmsp_pkg::TX_IDLE;
    endcase

    // Receive engine; the shift register frees rxBuf for software
    unique case (s_r.rxState)
      fmsp_pkg::RX_IDLE: begin
        if (s_r.mode == fmsp_pkg::MODE_SHIFT) begin
          if (s_r.rxEnable && !s_r.rxDone && !wrBuf &&
              s_r.txState == fmsp_pkg::TX_IDLE) begin
            s_nxt.rxState  = fmsp_pkg::RX_SYNC;
            s_nxt.rxBitCnt = 4'h0;
            s_nxt.shiftCnt = 4'h0;
            s_nxt.serialOut = 1'b1;
            s_nxt.lineOe   = 1'b0;
          end
        end else if (s_r.rxEnable && !rxLvl) begin
          s_nxt.rxState = fmsp_pkg::RX_START;
          s_nxt.rxTick  = 4'h0;
        end
      end
      fmsp_pkg::RX_START: begin
        if (osTick) begin
          s_nxt.rxTick = s_r.rxTick + 4'h1;
          if (s_r.rxTick == OS_MID) begin
            // A glitch that is high again at mid start is dropped
            s_nxt.rxTick   = 4'h0;
            s_nxt.rxBitCnt = 4'h0;
            s_nxt.rxState  = rxLvl ? fmsp_pkg::RX_IDLE
                                   : fmsp_pkg::RX_DATA;
          end
        end
      end
      fmsp_pkg::RX_DATA: begin
        if (osTick) begin
          s_nxt.rxTick = s_r.rxTick + 4'h1;
          if (s_r.rxTick == OS_LAST) begin
            s_nxt.rxShift  = {rxLvl, s_r.rxShift[9:1]};
            s_nxt.rxBitCnt = s_r.rxBitCnt + 4'h1;
            if (s_r.rxBitCnt == (nineBit ? 4'd9 : 4'd8)) begin
              s_nxt.rxState = fmsp_pkg::RX_IDLE;
              frame = {rxLvl, s_r.rxShift[9:1]};
              // 8-bit frames report the stop bit as ninth bit
              ninth = nineBit ? frame[8] : frame[9];
              // Filter passes only address bytes; no parity check
              if (!s_r.rxDone && (!s_r.mpFilter || ninth)) begin
                s_nxt.rxBuf   = nineBit ? frame[7:0]
                                        : frame[8:1];
                s_nxt.rxNinth = ninth;
                rxSet         = 1'b1;
              end
            end
          end
        end
      end
      fmsp_pkg::RX_SYNC: begin
        s_nxt.shiftCnt = s_r.shiftCnt + 4'h1;
        if (s_r.shiftCnt == SHIFT_FALL) begin
          s_nxt.serialOut = 1'b0;
        end
        if (s_r.shiftCnt == SHIFT_LAST) begin
          // Sampled late in the low phase, after the two-stage sync
          s_nxt.shiftCnt  = 4'h0;
          s_nxt.serialOut = 1'b1;
          s_nxt.rxShift   = {rxLvl, s_r.rxShift[9:1]};
          s_nxt.rxBitCnt  = s_r.rxBitCnt + 4'h1;
          if (s_r.rxBitCnt == 4'd7) begin
            s_nxt.rxState = fmsp_pkg::RX_IDLE;
            s_nxt.rxBuf   = {rxLvl, s_r.rxShift[9:3]};
            rxSet         = 1'b1;
          end
        end
      end
      default: s_nxt.rxState = fmsp_pkg::RX_IDLE;
    endcase

    // Register writes; a hardware set beats a software clear
    if (wrCtl) begin
      s_nxt.mode     = hwdata[`FMSP_CTL_MODE_HI:`FMSP_CTL_MODE_LO];
      s_nxt.mpFilter = hwdata[`FMSP_CTL_MPFILTER];
      s_nxt.rxEnable = hwdata[`FMSP_CTL_RXENABLE];
      s_nxt.txNinth  = hwdata[`FMSP_CTL_TXNINTH];
      s_nxt.txDone   = hwdata[`FMSP_CTL_TXDONE];
      s_nxt.rxDone   = hwdata[`FMSP_CTL_RXDONE];
      if (!rxSet) begin
        s_nxt.rxNinth = hwdata[`FMSP_CTL_RXNINTH];
      end
    end
    if (wrBaud) begin
      s_nxt.baudDouble = hwdata[`FMSP_BAUD_DOUBLE];
      s_nxt.txT2Sel    = hwdata[`FMSP_BAUD_TXT2];
      s_nxt.rxT2Sel    = hwdata[`FMSP_BAUD_RXT2];
    end
    s_nxt.txDone = s_nxt.txDone | txSet;
    s_nxt.rxDone = s_nxt.rxDone | rxSet;
  end

  // ========================================================================
  // State register, synchronous reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_r <= RST_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ========================================================================
  // Outputs, all taken from the state register
  assign hreadyout    = s_r.hreadyout;
  assign hrdata       = s_r.hrdata;
  assign hresp        = s_r.wrPend & 1'b0;  // Always OKAY
  assign serialInOut  = s_r.lineOe & 1'b0;  // Open drain, only pulls low
  assign serialInOe   = s_r.lineOe;
  assign serialOutPin = s_r.serialOut;
  assign wakeRequest  = s_r.wake;

endmodule : fmsp_serial_port

// ### test/fmsp_serial_port_properties.sv
/*
  Checker of the serial port: bus timing, pin shapes, wake pulses.
  Assumes a bind to fmsp_serial_port and sees only its ports.
*/
`timescale 1ns/10ps

module fmsp_serial_port_properties (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // Bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // Pins and power
  input wire logic        serialInOut,
  input wire logic        serialInOe,
  input wire logic        serialOutPin,
  input wire logic        powerManagedSlowMode,
  input wire logic        wakeRequest
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ==========
  // Transfers accepted at this edge
  logic takeRd;
  logic takeWr;
  assign takeRd = hsel & htrans[1] & hready & ~hwrite;
  assign takeWr = hsel & htrans[1] & hready & hwrite;

  // Read answer: one wait state, then ready
  sequence s_read_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  // Shift clock halves last at least six cycles
  sequence s_low6;
    (!serialOutPin) [*6];
  endsequence
  sequence s_high6;
    serialOutPin [*6];
  endsequence

  a_read_wait: assert property (takeRd |=> s_read_wait)
    else $error("read wait state wrong");
  a_write_nowait: assert property (takeWr |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_rdata_byte: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_od_low: assert property (serialInOut == 1'b0)
    else $error("data line driven high");
  a_clk_low: assert property ($fell(serialOutPin) |-> s_low6)
    else $error("output low too short");
  a_clk_high: assert property ($rose(serialOutPin) |-> s_high6)
    else $error("output high too short");
  a_data_hold: assert property (
    !serialOutPin |-> $stable(serialInOe))
    else $error("data moved while clock low");
  a_wake_pulse: assert property (wakeRequest |=> !wakeRequest)
    else $error("wake pulse too long");
  a_wake_slow: assert property (wakeRequest |->
    $past(powerManagedSlowMode, 1))
    else $error("wake outside slow mode");
endmodule : fmsp_serial_port_properties

bind fmsp_serial_port fmsp_serial_port_properties u_props (
  .mclk, .rst_n, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .hrdata, .hresp, .serialInOut, .serialInOe, .serialOutPin,
  .powerManagedSlowMode, .wakeRequest);

// ### test/fmsp_remote_uart.sv
/*
  Remote serial device: async frames both ways, shift-mode capture.
  Assumes tasks are called just after a rising edge of mclk.
*/
`timescale 1ns/10ps

module fmsp_remote_uart (
  // Clock
  input wire logic mclk,
  // Port output pin and shared data line level
  input wire logic txLine,
  input wire logic dataLine,
  // Our drive of the data line, 1 releases it
  output logic     rxDrive
);
  logic prevTx = 1'b1;
  initial rxDrive = 1'b1;

  // Previous output level, for fall detection
  always @(posedge mclk) prevTx <= txLine;

  // ==========
  // Start bit, nb bits LSB first, last one the stop bit
  task automatic sendFrame(input logic [9:0] bits, input int nb,
                           input int per);
    rxDrive <= 1'b0;
    repeat (per) @(posedge mclk);
    for (int i = 0; i < nb; i++) begin
      rxDrive <= bits[i];
      repeat (per) @(posedge mclk);
    end
    rxDrive <= 1'b1;
  endtask : sendFrame

  // Find start, sample bit centres
  task automatic recvFrame(input int nb, input int per,
                           output logic [9:0] got);
    int n;
    got = '0;
    n = 0;
    while (txLine !== 1'b0 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    repeat (per / 2) @(posedge mclk);
    for (int i = 0; i < nb; i++) begin
      repeat (per) @(posedge mclk);
      got[i] = txLine;
    end
  endtask : recvFrame

  // Shift mode: data valid at clock fall; last spacing returned
  task automatic recvShift(output logic [7:0] got, output int per,
                           output bit ok);
    int n;
    ok = 1'b1;
    per = 0;
    got = '0;
    for (int i = 0; i < 8; i++) begin
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (!(txLine === 1'b0 && prevTx === 1'b1) && n < 40);
      ok &= (n < 40);
      per = n;
      got[i] = dataLine;
    end
  endtask : recvShift

  // Shift mode: present each bit, move on after the clock rises
  task automatic sendShift(input logic [7:0] d);
    int n;
    for (int i = 0; i < 8; i++) begin
      rxDrive <= d[i];
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (!(txLine === 1'b1 && prevTx === 1'b0) && n < 40);
    end
    rxDrive <= 1'b1;
  endtask : sendShift

  // Short low pulse on the line: two edges
  task automatic glitch;
    rxDrive <= 1'b0;
    repeat (4) @(posedge mclk);
    rxDrive <= 1'b1;
  endtask : glitch
endmodule : fmsp_remote_uart

// ### test/tb_top.sv
/*
  Testbench of the serial port: register access, async frames in
  all rate settings, multiprocessor filter, shift send, wake.
  Assumes the remote model and the checker bind compile before it.
*/
`timescale 1ns/10ps
`include "fmsp_defines.svh"

module tb_top;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic        hreadyout, hresp, serialInOut, serialInOe;
  logic [31:0] hrdata;
  logic        serialOutPin, wakeRequest, rxDrive;
  logic        timer1Ovf = 1'b0;
  logic        timer2Ovf = 1'b0;
  logic        slowMode = 1'b0;
  wire         serialInPin;
  int          tCnt = 0;
  int          bad_count = 0;
  int          num_checks = 0;

  localparam logic [31:0] CTL = {22'h0, `FMSP_IDX_CONTROL, 2'h0};
  localparam logic [31:0] BUF = {22'h0, `FMSP_IDX_BUFFER, 2'h0};
  localparam logic [31:0] BAUD = {22'h0, `FMSP_IDX_BAUD, 2'h0};
  // Per case: control, baud setting and bit period in cycles
  localparam logic [7:0] ctlT [6] = '{8'h88, 8'h80, 8'h48, 8'h48, 8'h48,
                                      8'hC8};
  localparam logic [7:0] baudT [6] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h02,
                                       8'h04};
  localparam int perT [6] = '{64, 32, 32, 64, 48, 48};

  // ==========
  // Clock; timer1 every 2 cycles, timer2 every 3
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    tCnt <= tCnt + 1;
    timer1Ovf <= (tCnt % 2 == 0);
    timer2Ovf <= (tCnt % 3 == 0);
  end
  // Open-drain data line, remote side released is high
  assign serialInPin = serialInOe ? 1'b0 : rxDrive;

  fmsp_serial_port DUT (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .serialInPin(serialInPin),
    .serialInOut(serialInOut), .serialInOe(serialInOe),
    .serialOutPin(serialOutPin), .timer1Ovf(timer1Ovf),
    .timer2Ovf(timer2Ovf), .powerManagedSlowMode(slowMode),
    .wakeRequest(wakeRequest));

  fmsp_remote_uart uart (
    .mclk(mclk), .txLine(serialOutPin), .dataLine(serialInPin),
    .rxDrive(rxDrive));

  // ==========
  task automatic report_and_stop;
    $display("Checks: %0d, mismatches: %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  // Bounded wait for hready high at an edge
  task automatic waitReady;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      $display("Error at %0t: bus wait timed out", $time);
      report_and_stop();
    end
  endtask : waitReady

  // Single word transfer: address phase, then data phase
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    waitReady();
    htrans <= 2'h0;
    hwdata <= d;
    waitReady();
    q = hrdata;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, {24'h0, d}, q);
  endtask : wr

  task automatic rdChk(input logic [31:0] a, input logic [7:0] e);
    logic [31:0] q;
    xfer(a, 1'b0, '0, q);
    check(q, {24'h0, e});
  endtask : rdChk

  // Remote sends one frame; flags and buffer are then compared
  task automatic rxCase(input logic [7:0] c, input logic [7:0] b,
                        input int per, input logic [7:0] d,
                        input logic ninth, input logic [7:0] eC,
                        input logic [7:0] eB);
    wr(BAUD, b);
    wr(CTL, c);
    uart.sendFrame({1'b1, ninth | ~c[7], d}, c[7] ? 10 : 9, per);
    rdChk(CTL, eC);
    rdChk(BUF, eB);
  endtask : rxCase

  // ==========
  // Main sequence
  initial begin
    logic [9:0] got;
    logic [7:0] sb;
    int         per;
    int         w;
    bit         ok;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rdChk(CTL, `FMSP_RST_CONTROL);
    rdChk(BUF, `FMSP_RST_BUFFER);
    rdChk(BAUD, `FMSP_RST_BAUD);
    wr({22'h0, 8'h9B, 2'h0}, 8'h55);
    rdChk({22'h0, 8'h9B, 2'h0}, 8'h00);
    // Send in every async mode and rate setting
    for (int i = 0; i < 6; i++) begin
      wr(BAUD, baudT[i]);
      wr(CTL, ctlT[i]);
      fork
        wr(BUF, 8'hA5);
        uart.recvFrame(ctlT[i][7] ? 10 : 9, perT[i], got);
      join
      check(32'(got),
            {22'h0, ctlT[i][7], ctlT[i][3] | ~ctlT[i][7], 8'hA5});
      repeat (2 * perT[i]) @(posedge mclk);
      rdChk(CTL, ctlT[i] | 8'h02);
    end
    rdChk(BUF, 8'h00);
    // Receive in every async mode and rate setting
    for (int i = 0; i < 6; i++) begin
      rxCase(ctlT[i] & 8'hD0 | 8'h10, baudT[i], perT[i],
             8'h3C ^ 8'(i), 1'b1, ctlT[i] & 8'hC0 | 8'h15,
             8'h3C ^ 8'(i));
    end
    // Filter drops data bytes, takes address bytes
    rxCase(8'hB0, 8'h01, 32, 8'h11, 1'b0, 8'hB0, 8'h39);
    rxCase(8'hB0, 8'h01, 32, 8'h22, 1'b1, 8'hB5, 8'h22);
    // Shift mode send, then a write refused while done is set
    wr(CTL, 8'h00);
    fork
      wr(BUF, 8'h5A);
      uart.recvShift(sb, per, ok);
    join
    check({24'h0, sb}, 32'h5A);
    check(32'(per), `FMSP_SHIFT_DIV);
    check({31'h0, ok}, 32'h1);
    repeat (24) @(posedge mclk);
    rdChk(CTL, 8'h02);
    fork
      wr(BUF, 8'hC3);
      uart.recvShift(sb, per, ok);
    join
    check({31'h0, ok}, 32'h0);
    // Shift mode receive; enable write clears send-done as well
    fork
      wr(CTL, 8'h10);
      uart.sendShift(8'h96);
    join
    rdChk(CTL, 8'h11);
    rdChk(BUF, 8'h96);
    // Wake from slow mode on line edges, only with enable set
    slowMode <= 1'b1;
    wr(BAUD, 8'h01);
    for (int e = 1; e >= 0; e--) begin
      wr(CTL, 8'h40 | 8'(e << 4));
      fork
        uart.glitch();
        begin
          w = 0;
          repeat (24) begin
            @(posedge mclk);
            w += (wakeRequest === 1'b1);
          end
        end
      join
      check(32'(w), 32'(2 * e));
    end
    report_and_stop();
  end
endmodule : tb_top
